// ==== include/fcc_pkg.sv ====
// Package: register map, field positions and codes of the flash command control block
package fcc_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses, low address byte)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFF_TARGET = 8'h00;
    localparam logic [7:0]  OFF_CTRL   = 8'h08;
    localparam logic [7:0]  OFF_FLAGS  = 8'h24;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] TARGET_RST = 32'h1000_0000;

    // ------------------------------------------------------------------
    // Command control field positions
    // ------------------------------------------------------------------
    localparam int UNLOCK_LSB = 28;
    localparam int LVE_BIT    = 25;
    localparam int BUSY_BIT   = 24;
    localparam int KEY_LSB    = 8;
    localparam int WIDTH_BIT  = 4;
    localparam int PGE_BIT    = 2;
    localparam int ME_BIT     = 1;
    localparam int WR_BIT     = 0;

    // ------------------------------------------------------------------
    // Event flag field positions
    // ------------------------------------------------------------------
    localparam int FAIL_IE_BIT = 9;
    localparam int DONE_IE_BIT = 8;
    localparam int FAIL_BIT    = 1;
    localparam int DONE_BIT    = 0;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [3:0] UNLOCK_CODE = 4'h2;
    localparam logic [7:0] KEY_NONE    = 8'h00;
    localparam logic [7:0] KEY_PAGE    = 8'h55;
    localparam logic [7:0] KEY_MASS    = 8'hAA;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Kind of array operation
    typedef enum logic [1:0] {FCC_OP_PROG, FCC_OP_PAGE, FCC_OP_MASS} fcc_op_t;
endpackage : fcc_pkg

// ==== include/fcc_op_if.sv ====
// Interface: operation launch and completion between register file and sequencer
interface fcc_op_if;
    import fcc_pkg::*;
    logic        start;
    fcc_op_t     op;
    logic [31:0] addr;
    logic        busy;
    logic        finish;
    modport ctl (output start, output op, output addr, input busy, input finish);
    modport seq (input start, input op, input addr, output busy, output finish);
endinterface : fcc_op_if

// ==== rtl/fcc_seq.sv ====
// Operation sequencer: issues one array command and tracks busy until the array is done
module fcc_seq
    import fcc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    fcc_op_if.seq            op_bus,
    input  wire logic        array_done,
    output fcc_op_t          array_op,
    output logic             array_cmd_valid,
    output logic [31:0]      array_addr
);
    typedef enum logic {SEQ_IDLE, SEQ_WAIT} fcc_seq_state_t;

    typedef struct packed {
        fcc_seq_state_t state;
        logic           busy;
        logic           cmd;
        fcc_op_t        op;
        logic [31:0]    addr;
    } fcc_seq_st_t;

    fcc_seq_st_t st_reg;
    fcc_seq_st_t st_next;
    logic        fin;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next     = st_reg;
        st_next.cmd = 1'h0;
        fin         = 1'h0;
        unique case (st_reg.state)
            SEQ_IDLE:
            begin
                if (op_bus.start)
                begin
                    st_next.state = SEQ_WAIT;
                    st_next.busy  = 1'h1;
                    st_next.cmd   = 1'h1;
                    st_next.op    = op_bus.op;
                    st_next.addr  = op_bus.addr;
                end
            end
            SEQ_WAIT:
            begin
                // Done is ignored in the command cycle: the array cannot finish that fast
                if (array_done && !st_reg.cmd)
                begin
                    fin           = 1'h1;
                    st_next.busy  = 1'h0;
                    st_next.state = SEQ_IDLE;
                end
            end
        endcase
    end

    // Registered state, synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign op_bus.busy     = st_reg.busy;
    assign op_bus.finish   = fin;
    assign array_cmd_valid = st_reg.cmd;
    assign array_op        = st_reg.op;
    assign array_addr      = st_reg.addr;

    // Busy rises at the edge that takes the start
    a_busy_on_start: assert property (@(posedge aclk) disable iff (!aresetn)
        op_bus.start |=> op_bus.busy && array_cmd_valid)
        else $error("busy not raised after start");
endmodule : fcc_seq

// ==== rtl/fcc_top.sv ====
// Flash command control: AXI4-Lite registers, start bits, busy and event flags
//
// Behaviour
// - While busy, software writes to all registers except the event flags are ignored.
// - The busy bit is read-only and clears as soon as the array is accessible again.
// - A read, program or erase attempted while busy is refused and sets access failure.
// - The erase key selects erasing: 0x00 none, 0x55 page erase, 0xAA mass erase.
// - Hardware returns the erase key to zero when the erase finishes.
// - Writing 1 to page erase starts it; it reads 1 until hardware clears it at the end.
// - Writing 1 to mass erase starts it; hardware clears it when the erase is done.
// - Setting the program bit programs the array at the target address.
// - The program bit reads 1 while a program is pending or running, else 0.
// - Software writing 0 to the program bit has no effect; only hardware clears it.
// - Access failure is set on a program or erase attempt while busy or locked.
// - The completion flag is set each time a program or erase finishes.
//
// Local design decision: the AXI4-Lite register port.
module fcc_top
    import fcc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        flash_read_req,
    input  wire logic        array_done,
    output fcc_op_t          array_op,
    output logic             array_cmd_valid,
    output logic [31:0]      array_addr,
    output logic             irq
);
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        aw_have;
        logic [7:0]  awaddr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [31:0] target;
        logic [3:0]  unlock;
        logic        lve;
        logic [7:0]  key;
        logic        width;
        logic        pge;
        logic        me;
        logic        wr;
        logic        access_failure_flag;
        logic        done;
        logic        fail_ie;
        logic        done_ie;
        logic        irq;
    } fcc_top_st_t;

    fcc_top_st_t st_reg;
    fcc_top_st_t st_next;
    fcc_op_if    op_bus ();
    logic        busy;
    logic        start;
    fcc_op_t     op;
    logic        wr_fire;
    logic        fail_set;
    logic [31:0] ctrl_rd;
    logic [31:0] flags_rd;
    logic [31:0] ctrl_new;

    // ------------------------------------------------------------------
    // Byte-lane merge
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------------
    // Read views
    // ------------------------------------------------------------------
    assign busy = op_bus.busy;
    // Busy bit is a live view of the sequencer, never stored here
    assign ctrl_rd  = {st_reg.unlock, 2'h0, st_reg.lve, busy, 8'h00, st_reg.key,
                       3'h0, st_reg.width, 1'h0, st_reg.pge, st_reg.me, st_reg.wr};
    assign flags_rd = {22'h000000, st_reg.fail_ie, st_reg.done_ie, 6'h00,
                       st_reg.access_failure_flag, st_reg.done};
    assign ctrl_new = merge(ctrl_rd, st_reg.wdata, st_reg.wstrb);

    // ------------------------------------------------------------------
    // Next state: bus channels, register writes, hardware events
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        start   = 1'h0;
        op      = FCC_OP_PROG;
        wr_fire = 1'h0;
        fail_set = 1'h0;
        // Address and data are taken independently, in either order
        if (awvalid && st_reg.awready)
        begin
            st_next.aw_have = 1'h1;
            st_next.awaddr  = awaddr[7:0];
        end
        if (wvalid && st_reg.wready)
        begin
            st_next.w_have = 1'h1;
            st_next.wdata  = wdata;
            st_next.wstrb  = wstrb;
        end
        if (st_reg.bvalid && bready)
            st_next.bvalid = 1'h0;
        // Write is performed once both halves are held
        if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid)
        begin
            wr_fire         = 1'h1;
            st_next.aw_have = 1'h0;
            st_next.w_have  = 1'h0;
            st_next.bvalid  = 1'h1;
            st_next.bresp   = RESP_OKAY;
            case (st_reg.awaddr)
                OFF_TARGET:
                begin
                    if (!busy)
                        st_next.target = merge(st_reg.target, st_reg.wdata, st_reg.wstrb);
                end
                OFF_CTRL:
                begin
                    if (busy)
                    begin
                        // Start attempt during an operation is refused
                        if (st_reg.wstrb[0] && (st_reg.wdata[PGE_BIT] || st_reg.wdata[ME_BIT]
                            || st_reg.wdata[WR_BIT]))
                            fail_set = 1'h1;
                    end
                    else
                    begin
                        st_next.unlock = ctrl_new[UNLOCK_LSB +: 4];
                        st_next.lve    = ctrl_new[LVE_BIT];
                        st_next.key    = ctrl_new[KEY_LSB +: 8];
                        st_next.width  = ctrl_new[WIDTH_BIT];
                        // Start bits only set here; a written 0 never clears them
                        if (st_reg.wstrb[0] && (st_reg.wdata[PGE_BIT] || st_reg.wdata[ME_BIT]
                            || st_reg.wdata[WR_BIT]))
                        begin
                            if (ctrl_new[UNLOCK_LSB +: 4] != UNLOCK_CODE)
                                fail_set = 1'h1;
                            else if (st_reg.wdata[ME_BIT])
                            begin
                                // Key decides; a mismatched key counts as refused
                                if (ctrl_new[KEY_LSB +: 8] == KEY_MASS)
                                begin
                                    start      = 1'h1;
                                    op         = FCC_OP_MASS;
                                    st_next.me = 1'h1;
                                end
                                else
                                    fail_set = 1'h1;
                            end
                            else if (st_reg.wdata[PGE_BIT])
                            begin
                                if (ctrl_new[KEY_LSB +: 8] == KEY_PAGE)
                                begin
                                    start       = 1'h1;
                                    op          = FCC_OP_PAGE;
                                    st_next.pge = 1'h1;
                                end
                                else
                                    fail_set = 1'h1;
                            end
                            else
                            begin
                                start      = 1'h1;
                                op         = FCC_OP_PROG;
                                st_next.wr = 1'h1;
                            end
                        end
                    end
                end
                OFF_FLAGS:
                begin
                    // Flags and enables stay writable while busy
                    if (st_reg.wstrb[0] && st_reg.wdata[FAIL_BIT])
                        st_next.access_failure_flag = 1'h0;
                    if (st_reg.wstrb[0] && st_reg.wdata[DONE_BIT])
                        st_next.done = 1'h0;
                    if (st_reg.wstrb[1])
                    begin
                        st_next.fail_ie = st_reg.wdata[FAIL_IE_BIT];
                        st_next.done_ie = st_reg.wdata[DONE_IE_BIT];
                    end
                end
                default:
                    st_next.bresp = RESP_DECERR;
            endcase
        end
        // Flash read attempt during an operation
        if (flash_read_req && busy)
            fail_set = 1'h1;
        // Hardware events come last so a set beats a same-cycle clear
        if (fail_set)
            st_next.access_failure_flag = 1'h1;
        if (op_bus.finish)
        begin
            st_next.done = 1'h1;
            st_next.wr   = 1'h0;
            st_next.pge  = 1'h0;
            st_next.me   = 1'h0;
            if (st_reg.pge || st_reg.me)
                st_next.key = KEY_NONE;
        end
        // Read channel: one read in flight, answered the cycle after it is taken
        if (arvalid && st_reg.arready)
        begin
            st_next.rvalid = 1'h1;
            st_next.rresp  = RESP_OKAY;
            case (araddr[7:0])
                OFF_TARGET: st_next.rdata = st_reg.target;
                OFF_CTRL:   st_next.rdata = ctrl_rd;
                OFF_FLAGS:  st_next.rdata = flags_rd;
                default:
                begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rresp = RESP_DECERR;
                end
            endcase
        end
        if (st_reg.rvalid && rready)
            st_next.rvalid = 1'h0;
        // Ready terms come from the settled holding state
        st_next.arready = !st_next.rvalid && !(arvalid && st_reg.arready);
        st_next.awready = !st_next.aw_have && !st_next.bvalid;
        st_next.wready  = !st_next.w_have && !st_next.bvalid;
        st_next.irq     = (st_next.access_failure_flag && st_next.fail_ie)
                          || (st_next.done && st_next.done_ie);
    end

    // Registered state, synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg        <= '0;
            st_reg.target <= TARGET_RST;
        end
        else
            st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // Sequencer and outputs
    // ------------------------------------------------------------------
    assign op_bus.start = start;
    assign op_bus.op    = op;
    assign op_bus.addr  = st_reg.target;

    fcc_seq u_seq (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .op_bus          (op_bus),
        .array_done      (array_done),
        .array_op        (array_op),
        .array_cmd_valid (array_cmd_valid),
        .array_addr      (array_addr)
    );

    assign awready = st_reg.awready;
    assign wready  = st_reg.wready;
    assign bvalid  = st_reg.bvalid;
    assign bresp   = st_reg.bresp;
    assign arready = st_reg.arready;
    assign rvalid  = st_reg.rvalid;
    assign rresp   = st_reg.rresp;
    assign rdata   = st_reg.rdata;
    assign irq     = st_reg.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_busy_write_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && busy && !op_bus.finish && st_reg.awaddr != OFF_FLAGS |=> $stable(st_reg.target)
        && $stable(st_reg.key) && $stable(st_reg.unlock))
        else $error("register changed by a write while busy");
    a_busy_clears_done: assert property (@(posedge aclk) disable iff (!aresetn)
        op_bus.finish |=> !busy && !ctrl_rd[BUSY_BIT])
        else $error("busy still set after completion");
    a_read_busy_fail: assert property (@(posedge aclk) disable iff (!aresetn)
        flash_read_req && busy |=> st_reg.access_failure_flag)
        else $error("read while busy did not flag failure");
    a_erase_key_match: assert property (@(posedge aclk) disable iff (!aresetn)
        start && op != FCC_OP_PROG |=> (op_bus.busy && (st_reg.key == KEY_PAGE
        || st_reg.key == KEY_MASS)))
        else $error("erase started without a valid key");
    a_key_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
        op_bus.finish && (st_reg.pge || st_reg.me) |=> st_reg.key == KEY_NONE)
        else $error("erase key not cleared");
    a_page_bit_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.pge |-> busy)
        else $error("page erase bit set while idle");
    a_mass_bit_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        op_bus.finish && st_reg.me |=> !st_reg.me && st_reg.done)
        else $error("mass erase bit not cleared");
    a_prog_target: assert property (@(posedge aclk) disable iff (!aresetn)
        start && op == FCC_OP_PROG |=> array_cmd_valid && array_op == FCC_OP_PROG
        && array_addr == $past(st_reg.target))
        else $error("program not issued at target address");
    a_prog_bit_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.wr |-> busy && array_op == FCC_OP_PROG)
        else $error("program bit disagrees with sequencer");
    a_prog_no_sw_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.wr && !op_bus.finish |=> st_reg.wr)
        else $error("program bit cleared without completion");
    a_locked_fail: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && !busy && st_reg.awaddr == OFF_CTRL && st_reg.wstrb[0]
        && st_reg.wdata[WR_BIT] && ctrl_new[UNLOCK_LSB +: 4] != UNLOCK_CODE
        |=> st_reg.access_failure_flag && !busy)
        else $error("locked start not flagged");
    a_done_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        op_bus.finish |=> st_reg.done)
        else $error("completion flag not set");
endmodule : fcc_top

// ==== bench/fcc_array_model.sv ====
// Flash array model: answers each launch with a one-cycle completion, fast or slow
module fcc_array_model
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic cmd_valid,
    input  wire logic slow,
    output logic      done
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned count_reg;
    // Done never lands in the launch cycle, so the sequencer is already waiting
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_reg <= 0;
            done      <= 1'b0;
        end
        else if (cmd_valid)
        begin
            count_reg <= slow ? 80 : 1; // Slow leaves room for accesses while busy
            done      <= 1'b0;
        end
        else
        begin
            if (count_reg != 0)
                count_reg <= count_reg - 1;
            done <= (count_reg == 1);
        end
    end
endmodule : fcc_array_model

// ==== bench/flash_command_control_bench.sv ====
// Bench: register-level tests of the flash command control block
module flash_command_control_bench
    import fcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] UNL = {UNLOCK_CODE, 28'h0};
    localparam logic [31:0] BSY = 32'h1 << BUSY_BIT;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, flash_read_req, slow;
    logic [31:0] awaddr, wdata, araddr, rdata, array_addr, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, array_done, array_cmd_valid, irq;
    fcc_op_t     array_op;
    int          err_count, checked, cycles;
    logic [7:0]  keys [2] = '{KEY_PAGE, KEY_MASS};
    logic [31:0] bits [2] = '{32'h4, 32'h2};
    fcc_op_t     ops  [2] = '{FCC_OP_PAGE, FCC_OP_MASS};
    logic [31:0] bad  [3] = '{32'h1, UNL | 32'h5502, UNL | 32'h4};

    fcc_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .flash_read_req(flash_read_req), .array_done(array_done), .array_op(array_op),
        .array_cmd_valid(array_cmd_valid), .array_addr(array_addr), .irq(irq));
    fcc_array_model u_array (.aclk(aclk), .aresetn(aresetn), .cmd_valid(array_cmd_valid),
        .slow(slow), .done(array_done));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    // Unmapped offsets must answer with a decode error
    function automatic logic [31:0] resp_for(input logic [7:0] a);
        return (a == OFF_TARGET || a == OFF_CTRL || a == OFF_FLAGS) ? 32'(RESP_OKAY)
                                                                    : 32'(RESP_DECERR);
    endfunction : resp_for

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        logic fin;
        fin = 1'b0;
        @(posedge aclk);
        awaddr  <= {24'h0, a};
        wdata   <= v;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // Each half is released only at the edge that takes it
        while (!fin)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            fin = bvalid;
        end
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, resp_for(a));
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic fin;
        fin = 1'b0;
        @(posedge aclk);
        araddr  <= {24'h0, a};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!fin)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            fin = rvalid;
        end
        rready <= 1'b0;
        v = rdata;
        check("rresp", {30'h0, rresp}, resp_for(a));
    endtask : rd

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        check(n, d, e);
    endtask : rc

    // Bounded only by the run watchdog
    task automatic wait_idle();
        d = BSY;
        while (d[BUSY_BIT]) rd(OFF_CTRL, d);
    endtask : wait_idle

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_count++;
            finish_test();
        end
    end

    // Unlock goes with every start except the locked refusal case, width bit stays zero
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, flash_read_req} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb   = 4'hF;
        slow    = 1'b1;
        aresetn = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rc("target", OFF_TARGET, TARGET_RST);
        rc("ctrl", OFF_CTRL, 32'h0);
        rc("flags", OFF_FLAGS, 32'h0);
        rc("hole", 8'h04, 32'h0);
        wr(8'h04, 32'hFFFF_FFFF, 4'hF);
        $display("test reset done");
        wr(OFF_TARGET, 32'h0000_1230, 4'hF);
        wr(OFF_TARGET, 32'hFFFF_FFFF, 4'h3);
        wr(OFF_CTRL, UNL | 32'h1, 4'hF);
        check("addr", array_addr, 32'h0000_FFFF);
        check("op", 32'(array_op), 32'(FCC_OP_PROG));
        rc("ctrl", OFF_CTRL, UNL | BSY | 32'h1);
        wr(OFF_TARGET, 32'h0, 4'hF);
        wr(OFF_CTRL, UNL | 32'h1, 4'hF);
        rc("target", OFF_TARGET, 32'h0000_FFFF);
        wr(OFF_CTRL, 32'h0, 4'hF);
        rc("ctrl", OFF_CTRL, UNL | BSY | 32'h1);
        rc("flags", OFF_FLAGS, 32'h2);
        wr(OFF_FLAGS, 32'h302, 4'hF);
        rc("flags", OFF_FLAGS, 32'h300);
        @(posedge aclk) flash_read_req <= 1'b1;
        @(posedge aclk) flash_read_req <= 1'b0;
        rc("flags", OFF_FLAGS, 32'h302);
        wait_idle();
        rc("ctrl", OFF_CTRL, UNL);
        rc("flags", OFF_FLAGS, 32'h303);
        check("irq", {31'h0, irq}, 32'h1);
        wr(OFF_FLAGS, 32'h3, 4'hF);
        rc("flags", OFF_FLAGS, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        $display("test program done");
        for (int i = 0; i < 2; i++)
        begin
            wr(OFF_CTRL, UNL | {16'h0, keys[i], 8'h0} | bits[i], 4'hF);
            check("op", 32'(array_op), 32'(ops[i]));
            rc("ctrl", OFF_CTRL, UNL | BSY | {16'h0, keys[i], 8'h0} | bits[i]);
            wait_idle();
            rc("ctrl", OFF_CTRL, UNL);
            check("irq", {31'h0, irq}, 32'h0); // Done set but masked
        end
        wr(OFF_FLAGS, 32'h100, 4'hF);
        check("irq", {31'h0, irq}, 32'h1);
        wr(OFF_FLAGS, 32'h101, 4'hF);
        check("irq", {31'h0, irq}, 32'h0);
        $display("test erase done");
        // Locked, mass with page key, page with no key: all refused
        for (int i = 0; i < 3; i++)
        begin
            wr(OFF_FLAGS, 32'h3, 4'hF);
            wr(OFF_CTRL, bad[i], 4'hF);
            rc("flags", OFF_FLAGS, 32'h2);
            rd(OFF_CTRL, d);
            check("busy", {31'h0, d[BUSY_BIT]}, 32'h0);
        end
        slow <= 1'b0;
        wr(OFF_FLAGS, 32'h3, 4'hF);
        wr(OFF_CTRL, UNL | 32'h1, 4'hF);
        wait_idle();
        rc("flags", OFF_FLAGS, 32'h1);
        $display("test refusal done");
        finish_test();
    end
endmodule : flash_command_control_bench
